// *** rtl/uelr_map.vh ***
`ifndef UELR_MAP_VH
`define UELR_MAP_VH
// register addresses on the ulpi register path
`define UELR_ADDR_EVENT_LATCH   6'h14
`define UELR_ADDR_LINE_DEBUG    6'h15
`define UELR_ADDR_SCRATCH_WR    6'h16
`define UELR_ADDR_SCRATCH_SET   6'h17
`define UELR_ADDR_SCRATCH_CLR   6'h18
// event latch field positions
`define UELR_BIT_REMOTE_DETACH  0
`define UELR_BIT_BUS_POWER_OK   1
`define UELR_BIT_SESSION_OK     2
`define UELR_BIT_SESSION_OVER   3
`define UELR_BIT_ID_GROUNDED    4
`define UELR_NUM_EVENTS         5
// reset values
`define UELR_RST_LATCH          5'h00
`define UELR_RST_SCRATCH        8'h00
`define UELR_RST_EDGE_EN        5'h1F
// id pin settle time, link side only
`define UELR_ID_SETTLE_MS       50
`endif

// *** rtl/uelr_edge_detect.v ***
`timescale 1ns/1ps
`include "uelr_map.vh"
// synchronises event sources and flags enabled edges
module uelr_edge_detect #(
  parameter N = 5
) (
  input  wire         ref_clk_i,
  input  wire         nrst_i,
  input  wire [N-1:0] src_i,     // raw event sources
  input  wire [N-1:0] rise_en_i, // rising edge enables
  input  wire [N-1:0] fall_en_i, // falling edge enables
  output wire [N-1:0] level_o,   // synchronised level
  output wire [N-1:0] edge_o     // enabled edge, one cycle
);
  reg [N-1:0] sync1_ff; // first stage, read only by sync2
  reg [N-1:0] sync2_ff; // settled level
  reg [N-1:0] prev_ff;  // previous settled level

  // two-flop synchroniser plus history
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync1_ff <= {N{1'b0}};
      sync2_ff <= {N{1'b0}};
      prev_ff  <= {N{1'b0}};
    end else begin
      sync1_ff <= src_i;
      sync2_ff <= sync1_ff;
      prev_ff  <= sync2_ff;
    end
  end

  assign level_o = sync2_ff;
  // unmasked edges only; both enables off gives no events at all
  assign edge_o = (sync2_ff & ~prev_ff & rise_en_i) |
                  (~sync2_ff & prev_ff & fall_en_i);
endmodule // uelr_edge_detect

// *** rtl/uelr_event_latch.v ***
`timescale 1ns/1ps
`include "uelr_map.vh"
module uelr_event_latch #(
  parameter N = `UELR_NUM_EVENTS
) (
  input  wire         ref_clk_i,
  input  wire         nrst_i,
  input  wire         reg_rd_i,           // register read strobe, 1 cycle
  input  wire         reg_wr_i,           // register write strobe, 1 cycle
  input  wire [5:0]   reg_addr_i,         // register address
  input  wire [7:0]   reg_wdata_i,        // write data
  output wire [7:0]   reg_rdata_o,        // read data, valid with rvalid
  output wire         reg_rvalid_o,       // read data returned this cycle
  input  wire         remote_detach_seen_i, // raw event sources
  input  wire         bus_power_ok_i,
  input  wire         session_ok_i,
  input  wire         session_over_i,
  input  wire         id_pin_grounded_i,
  input  wire [N-1:0] rise_en_i,          // rising enables from enable regs
  input  wire [N-1:0] fall_en_i,          // falling enables
  input  wire         dplus_pulldown_en_i,
  input  wire         dminus_pulldown_en_i,
  input  wire         low_power_i,        // low-power mode level
  input  wire         serial6_i,          // six-pin serial mode level
  input  wire         serial3_i,          // three-pin serial mode level
  input  wire         line_level_bit0_i,  // line state, async
  input  wire         line_level_bit1_i,
  output wire [N-1:0] event_latch_o       // latch contents
);
  reg [7:0]   rdata_ff;    // registered read data
  reg         rvalid_ff;   // read data returned flag
  reg [N-1:0] latch_ff;    // event latch bits
  reg [7:0]   scratch_ff;  // test byte
  reg         lp_prev_ff;  // mode history for entry edges
  reg         s6_prev_ff;
  reg         s3_prev_ff;
  reg [2:0]   mode_s1_ff;  // mode synchroniser first stage
  reg [2:0]   mode_s2_ff;  // mode synchroniser second stage
  reg [1:0]   line_s1_ff;  // line state first stage
  reg [1:0]   line_s2_ff;  // line state second stage
  reg [N-1:0] nxt_latch;
  reg [7:0]   nxt_rdata;
  reg [7:0]   nxt_scratch;
  reg  [5:0]   reg_addr_q;  // address of the read in flight
  // the settled source levels are not used here; the status register
  // outside reads its own copy, so the level port is left open
  wire [N-1:0] edges;
  wire [N-1:0] sets;
  wire         host_mode;
  wire         mode_clear;
  wire         latch_read;

  // address match helper
  // used by the read mux, the scratch decode and the clear qualifier;
  // one function keeps the three decodes from drifting apart
  function is_addr;
    input [5:0] a;
    input [5:0] b;
    begin
      is_addr = (a == b);
    end
  endfunction

  // edge detection for the five event sources
  // sources arrive from the analog side with no clock relation, so the
  // edge block runs them through two flops before any edge is formed
  // the edge enables come from the enable registers outside this block;
  // those hold all ones after reset so every edge is unmasked
  // limitation: with both enables of a source off nothing is flagged
  // for it, so the detection for that source can be powered down
  // cost: two cycles from a source change to the edge strobe
  uelr_edge_detect #(.N(N)) u_edge (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .src_i     ({id_pin_grounded_i, session_over_i, session_ok_i,
                 bus_power_ok_i, remote_detach_seen_i}),
    .rise_en_i (rise_en_i),
    .fall_en_i (fall_en_i),
    .level_o   (),
    .edge_o    (edges)
  );

  // host mode needs both pulldowns; detach ignored otherwise
  assign host_mode = dplus_pulldown_en_i & dminus_pulldown_en_i;
  assign sets = {edges[N-1:1], edges[0] & host_mode};
  // entry edges of the clearing modes
  assign mode_clear = (mode_s2_ff[0] & ~lp_prev_ff) |
                      (mode_s2_ff[1] & ~s6_prev_ff) |
                      (mode_s2_ff[2] & ~s3_prev_ff);
  // read data is returned the cycle after the strobe
  // the clear uses the stored address of the read in flight, not the
  // live address, since the link may already present the next request
  // only a read of the latch address clears it; reads elsewhere leave
  // the bits alone
  assign latch_read = rvalid_ff &
                      is_addr(reg_addr_q, `UELR_ADDR_EVENT_LATCH);

  // next latch value, read and set resolution
  // priority: clearing first, then the return-cycle drop, then sets
  // a mode entry must win over a read of another register, otherwise
  // the latch would survive low-power or serial entry
  // sets in the strobe cycle already went into the read data, so the
  // bits they raise are cleared again by the latch read
  always @* begin
    nxt_latch = latch_ff; // hold until cleared
    if (latch_read | mode_clear)
      nxt_latch = {N{1'b0}};
    else if (rvalid_ff)
      // set colliding with returned read data is dropped
      nxt_latch = latch_ff;
    else
      nxt_latch = latch_ff | sets;
  end

  // read mux, collision sets fold into latch read data
  // the mux looks at the live address in the strobe cycle; its result
  // is captured only on a strobe, so the data stands until next read
  // reserved bits and unmapped addresses give zero
  // hazard: folding sets into the latch data is what keeps an event
  // from being lost when it lands in the strobe cycle
  always @* begin
    nxt_rdata = 8'h00; // unmapped and reserved read zero
    if (is_addr(reg_addr_i, `UELR_ADDR_EVENT_LATCH))
      nxt_rdata = {{(8-N){1'b0}}, latch_ff | sets};
    else if (is_addr(reg_addr_i, `UELR_ADDR_LINE_DEBUG))
      nxt_rdata = {6'h00, line_s2_ff};
    else if (reg_addr_i >= `UELR_ADDR_SCRATCH_WR &&
             reg_addr_i <= `UELR_ADDR_SCRATCH_CLR)
      nxt_rdata = scratch_ff;
  end

  // scratch write, set and clear; touches nothing else
  // writes to the latch, debug and unmapped addresses fall through and
  // leave every register unchanged
  // the byte feeds only the read mux, so no device function sees it
  always @* begin
    nxt_scratch = scratch_ff;
    if (reg_wr_i) begin
      if (is_addr(reg_addr_i, `UELR_ADDR_SCRATCH_WR))
        nxt_scratch = reg_wdata_i;
      else if (is_addr(reg_addr_i, `UELR_ADDR_SCRATCH_SET))
        nxt_scratch = scratch_ff | reg_wdata_i;
      else if (is_addr(reg_addr_i, `UELR_ADDR_SCRATCH_CLR))
        nxt_scratch = scratch_ff & ~reg_wdata_i;
    end
  end

  // register state
  // all flops share one asynchronous reset and load constants only
  // mode and line inputs are pin levels: two flops before any logic,
  // and only the second stage is read by the entry detect and the mux
  // entry into a mode is the rising edge of its settled level; the
  // history flops start low, so a mode held through reset still clears
  // rvalid follows the strobe by exactly one cycle
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      latch_ff   <= `UELR_RST_LATCH;
      scratch_ff <= `UELR_RST_SCRATCH;
      rdata_ff   <= 8'h00;
      rvalid_ff  <= 1'b0;
      reg_addr_q <= 6'h00;
      mode_s1_ff <= 3'h0;
      mode_s2_ff <= 3'h0;
      lp_prev_ff <= 1'b0;
      s6_prev_ff <= 1'b0;
      s3_prev_ff <= 1'b0;
      line_s1_ff <= 2'h0;
      line_s2_ff <= 2'h0;
    end else begin
      latch_ff   <= nxt_latch;
      scratch_ff <= nxt_scratch;
      rvalid_ff  <= reg_rd_i;
      if (reg_rd_i) begin
        rdata_ff   <= nxt_rdata;
        reg_addr_q <= reg_addr_i;
      end
      mode_s1_ff <= {serial3_i, serial6_i, low_power_i};
      mode_s2_ff <= mode_s1_ff;
      lp_prev_ff <= mode_s2_ff[0];
      s6_prev_ff <= mode_s2_ff[1];
      s3_prev_ff <= mode_s2_ff[2];
      line_s1_ff <= {line_level_bit1_i, line_level_bit0_i};
      line_s2_ff <= line_s1_ff;
    end
  end

  // outputs straight from flops
  // the latch contents go out as well so the event notification logic
  // outside can see pending bits without a register read
  assign reg_rdata_o   = rdata_ff;
  assign reg_rvalid_o  = rvalid_ff;
  assign event_latch_o = latch_ff;
endmodule // uelr_event_latch

// *** tb/uelr_event_latch_sva.sv ***
`timescale 1ns/1ps
// watches the register path, the latch outputs and the bus power, pulldown and mode inputs
module uelr_sva (
  input wire       ref_clk_i,
  input wire       nrst_i,
  input wire       reg_rd_i,
  input wire [5:0] reg_addr_i,
  input wire [7:0] reg_rdata_o,
  input wire       reg_rvalid_o,
  input wire       bus_power_ok_i,
  input wire       dplus_pulldown_en_i,
  input wire       dminus_pulldown_en_i,
  input wire       low_power_i,
  input wire       serial6_i,
  input wire       serial3_i,
  input wire [4:0] event_latch_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  wire rd14 = reg_rd_i && reg_addr_i == 6'h14; // latch read strobe
  rv_follow_a: assert property (reg_rvalid_o == $past(reg_rd_i))
    else $error("read answer late");
  rd_clear_a: assert property (rd14 |=> ##1 event_latch_o == 5'h00)
    else $error("latch kept after read");
  fold_data_a: assert property (reg_rvalid_o && $past(rd14) |->
    (reg_rdata_o[4:0] & $past(event_latch_o)) == $past(event_latch_o))
    else $error("latch lost from read data");
  resv_zero_a: assert property ($past(rd14) |->
    reg_rdata_o[7:5] == 3'h0) else $error("reserved latch bits set");
  set_edge_a: assert property ($rose(bus_power_ok_i) ##0
    (!reg_rd_i)[*7] |-> event_latch_o[1]) else $error("edge not latched");
  host_only_a: assert property ($rose(event_latch_o[0]) |->
    $past(dplus_pulldown_en_i && dminus_pulldown_en_i))
    else $error("detach latched outside host mode");
  lp_clear_a: assert property ($rose(low_power_i) |->
    ##[1:6] event_latch_o == 5'h00) else $error("low power kept latch");
  ser_clear_a: assert property ($rose(serial6_i) || $rose(serial3_i)
    |-> ##[1:6] event_latch_o == 5'h00) else $error("serial kept latch");
  cover property (rd14 ##1 reg_rdata_o != 8'h00);
  cover property ($rose(low_power_i));
  cover property ($rose(event_latch_o[0]));
endmodule // uelr_sva
bind uelr_event_latch uelr_sva u_sva (.*);

// *** tb/uelr_link_model.sv ***
`timescale 1ns/1ps
// link side of the register path; lines move 1 ns after an edge
module uelr_link_model (
  input  wire        ref_clk_i,
  input  wire  [7:0] rdata_i,
  input  wire        rvalid_i,
  output logic       rd_o = 1'b0,
  output logic       wr_o = 1'b0,
  output logic [5:0] addr_o = 6'h00,
  output logic [7:0] wdata_o = 8'h00
);
  // strobe held to the taking edge, answer taken the cycle after
  task rd(input logic [5:0] a, output logic [7:0] d);
    {rd_o, wr_o, addr_o} = {2'b10, a};
    @(posedge ref_clk_i) #1;
    d = rvalid_i ? rdata_i : 8'hXX; // a missing answer never matches
  endtask
  task wr(input logic [5:0] a, input logic [7:0] v);
    {rd_o, wr_o, addr_o, wdata_o} = {2'b01, a, v};
    @(posedge ref_clk_i) #1;
  endtask
  // released lines show the inverse, never a stale copy
  task idle;
    {rd_o, wr_o, addr_o, wdata_o} = {2'b00, ~addr_o, ~wdata_o};
    @(posedge ref_clk_i) #1;
  endtask
endmodule // uelr_link_model

// *** tb/uelr_event_latch_test.sv ***
`timescale 1ns/1ps
module uelr_event_latch_test;
  logic       ref_clk_i = 1'b0; // 200 MHz
  logic       nrst_i = 1'b0;
  logic [4:0] src = 5'h00;      // sources in latch bit order
  logic [4:0] fall_en = 5'h1F;
  logic [4:0] rise_en = 5'h1F;
  logic [1:0] line = 2'h2;      // line state levels
  logic [2:0] md = 3'h0;        // low power, serial6, serial3
  logic       host = 1'b1;      // both pulldowns
  logic       reg_rd_i, reg_wr_i, reg_rvalid_o;
  logic [5:0] reg_addr_i;
  logic [7:0] reg_wdata_i, reg_rdata_o, d;
  logic [4:0] event_latch_o;
  int         n_errors = 0, n_checks = 0, hits;
  always #2.5 ref_clk_i = ~ref_clk_i;
  uelr_event_latch u_dut (.*, .remote_detach_seen_i(src[0]),
    .bus_power_ok_i(src[1]), .session_ok_i(src[2]), .session_over_i(src[3]),
    .id_pin_grounded_i(src[4]), .rise_en_i(rise_en), .fall_en_i(fall_en),
    .dplus_pulldown_en_i(host), .dminus_pulldown_en_i(host),
    .low_power_i(md[0]), .serial6_i(md[1]), .serial3_i(md[2]),
    .line_level_bit0_i(line[0]), .line_level_bit1_i(line[1]));
  uelr_link_model u_link (.ref_clk_i, .rdata_i(reg_rdata_o),
    .rvalid_i(reg_rvalid_o), .rd_o(reg_rd_i), .wr_o(reg_wr_i),
    .addr_o(reg_addr_i), .wdata_o(reg_wdata_i));
  task chk(input logic [7:0] s, e);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task rdc(input logic [5:0] a, input logic [7:0] e);
    u_link.rd(a, d);
    u_link.idle();
    chk(d, e);
  endtask
  // flip a source, leave time to cross the synchroniser
  task ev(input int b);
    src[b] = ~src[b];
    cyc(8);
  endtask
  initial begin
    #20000;
    n_errors++;
    test_done();
  end
  initial begin
    cyc(8);
    nrst_i = 1'b1;
    cyc(4);
    rdc(6'h14, 8'h00);
    rdc(6'h15, 8'h02);
    line = 2'h1;
    cyc(4);
    rdc(6'h15, 8'h01);
    rdc(6'h16, 8'h00);
    rdc(6'h3F, 8'h00);
    u_link.wr(6'h16, 8'hA5);
    u_link.wr(6'h17, 8'h0A);
    u_link.wr(6'h18, 8'h05);
    u_link.wr(6'h14, 8'hFF);
    u_link.idle();
    rdc(6'h18, 8'hAA);
    rdc(6'h14, 8'h00);
    $display("register map test ends");
    ev(1);
    rdc(6'h14, 8'h02);
    rdc(6'h14, 8'h00);
    fall_en = 5'h1D;
    ev(1);
    rdc(6'h14, 8'h00);
    host = 1'b0;
    ev(0);
    rdc(6'h14, 8'h00);
    host = 1'b1;
    ev(0);
    rdc(6'h14, 8'h01);
    for (int i = 0; i < 3; i++) begin
      ev(3);
      cyc(20);
      chk({3'h0, event_latch_o}, 8'h08);
      md[i] = 1'b1;
      cyc(8);
      chk({3'h0, event_latch_o}, 8'h00);
      md[i] = 1'b0;
    end
    {rise_en, fall_en} = 10'h000;
    ev(2);
    ev(2);
    rdc(6'h14, 8'h00);
    {rise_en, fall_en} = 10'h3FF;
    src[4] = 1'b1;
    hits = 0;
    repeat (12) begin
      u_link.rd(6'h14, d);
      hits += d[4];
    end
    u_link.idle();
    chk(8'(hits), 8'h01);
    chk({3'h0, event_latch_o}, 8'h00);
    $display("event test ends");
    test_done();
  end
endmodule // uelr_event_latch_test
